// file: core/boundary_scan_chain.sv
`timescale 1ns/1ps
`include "scan_chain_defines.svh"
module boundary_scan_chain
  import scan_chain_pkg::*;
#(
  parameter int LEN = `CHAIN_LEN
) (
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // Test access pins and controller state
  input  wire logic           tck_i,
  input  wire logic           tdi_i,
  input  wire logic           capture_dr_i,
  input  wire logic           shift_dr_i,
  input  wire logic           update_dr_i,
  input  wire logic           external_test_instruction_i,
  input  wire logic           snapshot_preload_instruction_i,
  output logic                tdo_o,
  output logic                tdo_oe_o,
  // Device pins
  input  wire logic [LEN-1:0] pin_in_i,
  output logic      [LEN-1:0] pin_out_o,
  output logic      [LEN-1:0] pin_oe_o,
  // System logic side
  input  wire logic [LEN-1:0] core_out_i,
  input  wire logic [LEN-1:0] core_oe_i,
  output logic                system_reset_o,
  // Wishbone slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o
);

  // ----------------------------------------
  // Cell map
  // ----------------------------------------
  function automatic logic [7:0] ctl_of(input int i);
    if (i <= 26 || (i >= 105 && i <= 110) || i == 102) begin
      return 8'(`ADDRESS_BUS_ENABLE_BIT);
    end else if (i == 103 || i == 104 || i == 114) begin
      return 8'(`BERR_CTL_BIT);
    end else if (i >= 67 && i <= 82) begin
      return 8'(`DATA_BUS_ENABLE_BIT);
    end else if (i == `TIMER2_OUTPUT_PIN_DATA_BIT) begin
      return 8'(`TIMER2_OUTPUT_ENABLE_BIT);
    end else if (i == `TOUT1_DATA_BIT) begin
      return 8'(`TIMER1_OUTPUT_ENABLE_BIT);
    end else if (i >= 51 && i <= 65 && (i % 2) == 1) begin
      return 8'(i + 1);
    end else if (i >= 86 && i <= 100 && (i % 2) == 0) begin
      return 8'(i + 1);
    end else if (i == 121 || i == 124) begin
      return 8'(i + 1);
    end
    return `NO_CTL;
  endfunction

  function automatic logic is_open_drain(input int i);
    return i == `TRANSFER_DONE_PIN_1_OUT_BIT || i == `TRANSFER_DONE_PIN_2_OUT_BIT || i == `HALT_OUT_BIT || i == `RESET_OUT_BIT;
  endfunction

  function automatic cell_kind_type kind_of(input int i);
    if (i == `ADDRESS_BUS_ENABLE_BIT || i == `DATA_BUS_ENABLE_BIT) begin
      return CELL_CTL_HIGH;
    end else if (i == `TIMER2_OUTPUT_ENABLE_BIT || i == `BERR_CTL_BIT || i == `TIMER1_OUTPUT_ENABLE_BIT || i == 122 || i == 125 ||
                 (i >= 52 && i <= 66 && (i % 2) == 0) || (i >= 87 && i <= 101 && (i % 2) == 1)) begin
      return CELL_CTL_LOW;
    end else if (i == 28 || i == 32 || i == 33 || i == 35 || i == 36 || i == 38 || i == 39 || i == 44 ||
                 i == 48 || i == 112 || i == 119 || i == 123 || i == 127 || i == 129 || is_open_drain(i)) begin
      return CELL_OUTPUT;
    end else if (ctl_of(i) != `NO_CTL) begin
      return CELL_BIDIR;
    end
    return CELL_INPUT;
  endfunction

  function automatic logic [LEN-1:0] latch_reset_vec();
    logic [LEN-1:0] v;
    v = '0;
    for (int i = 0; i < LEN; i++) begin
      v[i] = (kind_of(i) == CELL_CTL_LOW) || is_open_drain(i);
    end
    return v;
  endfunction

  localparam logic [LEN-1:0] LATCH_RESET = latch_reset_vec();

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [6:0]     ctl_meta;
  logic [6:0]     ctl_s;
  logic [LEN-1:0] pin_meta;
  logic [LEN-1:0] pin_s;
  logic           tck_d;
  logic           tck_s;
  logic           tdi_s;
  logic           capture_s;
  logic           shift_s;
  logic           update_s;
  logic           external_test_instruction_s;
  logic           sample_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_meta <= '0;
      ctl_s    <= '0;
    end else begin
      ctl_meta <= {tck_i, tdi_i, capture_dr_i, shift_dr_i, update_dr_i,
                   external_test_instruction_i, snapshot_preload_instruction_i};
      ctl_s    <= ctl_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_s    <= '0;
    end else begin
      pin_meta <= pin_in_i;
      pin_s    <= pin_meta;
    end
  end

  assign {tck_s, tdi_s, capture_s, shift_s, update_s, external_test_instruction_s, sample_s} = ctl_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  // ----------------------------------------
  // Chain control
  // ----------------------------------------
  scan_ctrl_if #(.LEN(LEN)) sc ();

  logic chain_selected;
  assign chain_selected = external_test_instruction_s || sample_s;

  assign sc.tck_rise = tck_s && !tck_d;
  assign sc.tck_fall = !tck_s && tck_d;
  assign sc.capture  = capture_s && chain_selected;
  assign sc.shift    = shift_s && chain_selected;
  assign sc.update   = update_s && chain_selected;
  assign sc.tdi      = tdi_s;

  generate
    for (genvar g = 0; g < LEN; g++) begin : g_cap
      if (kind_of(g) == CELL_INPUT || kind_of(g) == CELL_BIDIR) begin : g_pin
        assign sc.cap_data[g] = pin_s[g];
      end else begin : g_core
        assign sc.cap_data[g] = core_out_i[g];
      end
    end
  endgenerate

  scan_shift_register #(
    .LEN         (LEN),
    .LATCH_RESET (LATCH_RESET)
  ) u_shift (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sc    (sc.regs)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o    <= sc.tdo_bit;
      if (sc.tck_fall) begin
        tdo_oe_o <= sc.shift;
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [LEN-1:0] next_pin_out;
  logic [LEN-1:0] next_pin_oe;

  generate
    for (genvar g = 0; g < LEN; g++) begin : g_pin
      localparam logic [7:0] C = ctl_of(g);
      logic test_oe;
      logic test_out;
      if (is_open_drain(g)) begin : g_od
        assign test_oe  = !sc.latch[g];
        assign test_out = 1'b0;
      end else if (kind_of(g) == CELL_INPUT || kind_of(g) == CELL_CTL_LOW ||
                   kind_of(g) == CELL_CTL_HIGH) begin : g_none
        assign test_oe  = 1'b0;
        assign test_out = 1'b0;
      end else if (C == `NO_CTL) begin : g_out
        assign test_oe  = 1'b1;
        assign test_out = sc.latch[g];
      end else if (kind_of(int'(C)) == CELL_CTL_HIGH) begin : g_high
        assign test_oe  = sc.latch[C];
        assign test_out = sc.latch[g];
      end else begin : g_low
        assign test_oe  = !sc.latch[C];
        assign test_out = sc.latch[g];
      end
      assign next_pin_oe[g]  = external_test_instruction_s ? test_oe : core_oe_i[g];
      assign next_pin_out[g] = external_test_instruction_s ? test_out : core_out_i[g];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_oe_o  <= '0;
      pin_out_o <= '0;
    end else begin
      pin_oe_o  <= next_pin_oe;
      pin_out_o <= next_pin_out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_reset_o <= 1'b0;
    end else begin
      system_reset_o <= external_test_instruction_s;
    end
  end

  // ----------------------------------------
  // Wishbone registers
  // ----------------------------------------
  logic [2:0]  word_sel;
  logic        wb_req;
  logic [31:0] next_dat;
  logic [255:0] latch_wide;
  logic [255:0] chain_wide;

  assign wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign latch_wide = {{(256 - LEN){1'b0}}, sc.latch};
  assign chain_wide = {{(256 - LEN){1'b0}}, sc.chain};

  always_comb begin
    case (wb_adr_i)
      `REG_STATUS:     next_dat = {28'h0000000, tdo_oe_o, shift_s, sample_s, external_test_instruction_s};
      `REG_WORD_SEL:   next_dat = {29'h00000000, word_sel};
      `REG_LATCH_WORD: next_dat = latch_wide[word_sel*32 +: 32];
      `REG_CHAIN_WORD: next_dat = chain_wide[word_sel*32 +: 32];
      default:         next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_sel <= 3'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_WORD_SEL) begin
      word_sel <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? next_dat : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_shift_in;
    @(posedge clk_i) disable iff (rst_i)
      (sc.tck_rise && sc.shift && !sc.capture) |=>
        (sc.chain[LEN-1] == $past(tdi_s)) && (sc.chain[0] == $past(sc.chain[1]));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("chain did not shift toward output");

  property p_tdo_fall;
    @(posedge clk_i) disable iff (rst_i)
      sc.tck_fall |=> ##1 (tdo_o == $past(sc.chain[0], 2));
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("serial output not updated on falling edge");

  property p_tdo_quiet;
    @(posedge clk_i) disable iff (rst_i)
      (sc.tck_fall && !shift_s) |=> !tdo_oe_o;
  endproperty
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("serial output driven outside shift");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
      (sc.tck_rise && sc.capture) |=> (sc.chain[`TRANSFER_DONE_PIN_1_IN_BIT] == $past(pin_s[`TRANSFER_DONE_PIN_1_IN_BIT]));
  endproperty
  a_capture: assert property (p_capture) else $error("pin snapshot not captured");

  property p_open_drain;
    @(posedge clk_i) disable iff (rst_i)
      $past(external_test_instruction_s) |-> !pin_out_o[`TRANSFER_DONE_PIN_1_OUT_BIT] && !pin_out_o[`HALT_OUT_BIT] &&
                         (pin_oe_o[`TRANSFER_DONE_PIN_2_OUT_BIT] == !$past(sc.latch[`TRANSFER_DONE_PIN_2_OUT_BIT]));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");

  property p_irq7;
    @(posedge clk_i) disable iff (rst_i)
      $past(external_test_instruction_s) |-> (pin_oe_o[`IRQ7_DATA_BIT] == !$past(sc.latch[`LEVEL7_REQUEST_ENABLE_BIT]));
  endproperty
  a_irq7: assert property (p_irq7) else $error("level-7 enable polarity wrong");

  property p_address;
    @(posedge clk_i) disable iff (rst_i)
      $past(external_test_instruction_s) |-> (pin_oe_o[0] == $past(sc.latch[`ADDRESS_BUS_ENABLE_BIT])) &&
                         (pin_oe_o[26] == $past(sc.latch[`ADDRESS_BUS_ENABLE_BIT]));
  endproperty
  a_address: assert property (p_address) else $error("address enable not high-active");

  property p_timer2_output_pin;
    @(posedge clk_i) disable iff (rst_i)
      $past(external_test_instruction_s) |-> (pin_oe_o[`TIMER2_OUTPUT_PIN_DATA_BIT] == !$past(sc.latch[`TIMER2_OUTPUT_ENABLE_BIT]));
  endproperty
  a_timer2_output_pin: assert property (p_timer2_output_pin) else $error("timer-2 output enable wrong");

  property p_data_group;
    @(posedge clk_i) disable iff (rst_i)
      $past(external_test_instruction_s) |-> (pin_oe_o[82:67] == {16{$past(sc.latch[`DATA_BUS_ENABLE_BIT])}});
  endproperty
  a_data_group: assert property (p_data_group) else $error("data bus cells not sharing enable");

  property p_system_reset;
    @(posedge clk_i) disable iff (rst_i)
      external_test_instruction_s ##1 external_test_instruction_s |-> system_reset_o;
  endproperty
  a_system_reset: assert property (p_system_reset) else $error("system not held in reset");

  property p_update;
    @(posedge clk_i) disable iff (rst_i)
      (sc.tck_rise && sc.update) |=> (sc.latch == $past(sc.chain));
  endproperty
  a_update: assert property (p_update) else $error("update latches not loaded");

  property p_functional;
    @(posedge clk_i) disable iff (rst_i)
      !$past(external_test_instruction_s) |-> (pin_oe_o == $past(core_oe_i)) && (pin_out_o == $past(core_out_i));
  endproperty
  a_functional: assert property (p_functional) else $error("latches reached pins outside test");

endmodule

// file: core/scan_chain_defines.svh
`ifndef SCAN_CHAIN_DEFINES_SVH
`define SCAN_CHAIN_DEFINES_SVH
// Contract
// - One serial data chain of exactly 132 bits covering digital, clock and control cells.
// - Crystal and loop filter pins have no cells in the chain.
// - Each ordinary two-way pin has one data cell tied to a control cell.
// - Open-drain pins get an output latch and an input cell, no control.
// - Twenty-three control cells each enable a group of pins.
// - Bit 0 sits next to the serial output and leaves first; bit 131 last.
// - Low-active control cells enable on zero, high-active on one.
// - High-active address enable at bit 83 drives bits 0 to 26.
// - Low-active level-7 request enable at bit 52 drives data bit 51.
// - Control cells sit at fixed bits 29, 52-66 even, 83-85, 87-101 odd, 122, 125, 130.
// - Every pin cell has a fixed position, e.g. transfer-done latches at 45 and 49.
// - Five cell kinds: input, output latch, two-way data, low and high control.
// - Timer-2 output at bit 28 is three-state, gated by low control at 29.
// - Open-drain outputs are only released or driven low, never high; outside external test the code passes core_out_i and core_oe_i through.
// - Control cell value sets whether its two-way pins are inputs or outputs.
// - One control cell may govern several data cells, like the sixteen data bits.
// - Serial input taken on rising test clock, output changes on falling, driven only in shift.
// - Pin snapshot captured on rising test clock in capture state.
// - External test selects the chain and holds system logic in reset.

`define CHAIN_LEN        132
`define CTL_CELL_COUNT   23
`define SYNC_STAGES      2
`define ADDRESS_BUS_ENABLE_BIT       83
`define BERR_CTL_BIT     84
`define DATA_BUS_ENABLE_BIT       85
`define IRQ7_DATA_BIT    51
`define LEVEL7_REQUEST_ENABLE_BIT     52
`define TIMER2_OUTPUT_PIN_DATA_BIT   28
`define TIMER2_OUTPUT_ENABLE_BIT    29
`define TOUT1_DATA_BIT   129
`define TIMER1_OUTPUT_ENABLE_BIT    130
`define TRANSFER_DONE_PIN_1_OUT_BIT    45
`define TRANSFER_DONE_PIN_1_IN_BIT     46
`define TRANSFER_DONE_PIN_2_OUT_BIT    49
`define TRANSFER_DONE_PIN_2_IN_BIT     50
`define HALT_OUT_BIT     115
`define RESET_OUT_BIT    117
`define NO_CTL           8'hFF
`define REG_STATUS       8'h00
`define REG_WORD_SEL     8'h04
`define REG_LATCH_WORD   8'h08
`define REG_CHAIN_WORD   8'h0C
`endif

// file: core/scan_chain_pkg.sv
package scan_chain_pkg;
  // Cell kinds, one-hot
  typedef enum logic [4:0] {
    CELL_INPUT    = 5'b00001,
    CELL_OUTPUT   = 5'b00010,
    CELL_BIDIR    = 5'b00100,
    CELL_CTL_LOW  = 5'b01000,
    CELL_CTL_HIGH = 5'b10000
  } cell_kind_type;
endpackage

// file: core/scan_ctrl_if.sv
`timescale 1ns/1ps
interface scan_ctrl_if #(parameter int LEN = 132);
  logic           tck_rise;
  logic           tck_fall;
  logic           capture;
  logic           shift;
  logic           update;
  logic           tdi;
  logic [LEN-1:0] cap_data;
  logic [LEN-1:0] chain;
  logic [LEN-1:0] latch;
  logic           tdo_bit;
  modport ctrl (output tck_rise, tck_fall, capture, shift, update, tdi, cap_data,
                input chain, latch, tdo_bit);
  modport regs (input tck_rise, tck_fall, capture, shift, update, tdi, cap_data,
                output chain, latch, tdo_bit);
endinterface

// file: core/scan_shift_register.sv
`timescale 1ns/1ps
`include "scan_chain_defines.svh"
module scan_shift_register
  import scan_chain_pkg::*;
#(
  parameter int              LEN         = `CHAIN_LEN,
  parameter logic [LEN-1:0]  LATCH_RESET = '0
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control side
  scan_ctrl_if.regs sc
);
  logic [LEN-1:0] chain;
  logic [LEN-1:0] latch;
  logic           tdo_bit;

  // ----------------------------------------
  // Shift and capture
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain <= '0;
    end else if (sc.tck_rise && sc.capture) begin
      chain <= sc.cap_data;
    end else if (sc.tck_rise && sc.shift) begin
      chain <= {sc.tdi, chain[LEN-1:1]};
    end
  end

  // ----------------------------------------
  // Update latches
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch <= LATCH_RESET;
    end else if (sc.tck_rise && sc.update) begin
      latch <= chain;
    end
  end

  // ----------------------------------------
  // Serial output on falling edge
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_bit <= 1'b0;
    end else if (sc.tck_fall) begin
      tdo_bit <= chain[0];
    end
  end

  assign sc.chain   = chain;
  assign sc.latch   = latch;
  assign sc.tdo_bit = tdo_bit;
endmodule

// file: verification/tap_master_model.sv
`timescale 1ns/1ps
module tap_master_model (
  // Test clock, data and controller state
  output logic      tck_o,
  output logic      tdi_o,
  output logic      capture_o,
  output logic      shift_o,
  output logic      update_o,
  // Serial return
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  // --------------------------------
  // Idle: clock stands low, data pulled up
  // --------------------------------
  initial begin
    tck_o = 1'b0;
    tdi_o = 1'b1;
    capture_o = 1'b0;
    shift_o = 1'b0;
    update_o = 1'b0;
  end
  // One period; state moves after the rise, output taken before the fall
  task automatic tick(input logic c, input logic s, input logic u, input logic d,
                      output logic q, output logic oe);
    tck_o = 1'b1;
    #10;
    capture_o = c;
    shift_o = s;
    update_o = u;
    tdi_o = d;
    #14;
    q = tdo_i;
    oe = tdo_oe_i;
    tck_o = 1'b0;
    #24;
  endtask
  // Capture, 132 shifts, update; counts periods with the output driven
  task automatic scan(input logic [131:0] din, output logic [131:0] dout, output int oe_hi);
    logic q;
    logic oe;
    oe_hi = 0;
    tick(1'b1, 1'b0, 1'b0, 1'b1, q, oe);
    tick(1'b0, 1'b1, 1'b0, din[0], q, oe);
    for (int i = 0; i < 132; i++) begin
      tick(1'b0, i < 131, i == 131, (i < 131) ? din[(i+1)%132] : 1'b1, dout[i], oe);
      oe_hi += (oe === 1'b1);
    end
    tick(1'b0, 1'b0, 1'b0, 1'b1, q, oe);
  endtask
endmodule

// file: verification/tb_boundary_scan_chain.sv
`timescale 1ns/1ps
`include "scan_chain_defines.svh"
module tb_boundary_scan_chain
  import scan_chain_pkg::*;
;
  `define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t %s", $time, m); end end
  localparam logic [131:0] V1 = 132'hA_5A5A_C3C3_0F0F_9696_F00F_1234_ABCD_E5E6;
  localparam logic [131:0] V2 = 132'hC_96C3_5AA5_0FF0_3C3C_6969_A5A5_1E1E_E1E1;
  localparam logic [131:0] V3 = 132'h5_F0F0_3355_AA99_CC66_0F1E_2D3C_4B5A_6978;
  localparam logic [131:0] P  = 132'h3_0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic         clk_i = 1'b0, rst_i = 1'b1;
  logic         tck, tdi, cap, sh, upd, tdo, tdo_oe, sys_rst;
  logic         ext = 1'b0, smp = 1'b0;
  logic [131:0] pin_in = '0, core_out = '0, core_oe = '0, pin_out, pin_oe, v, d;
  logic         wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0]   wb_adr = 8'h00;
  logic [31:0]  wb_wdat = 32'h0, wb_rdat, q;
  int           error_cnt = 0, num_checks = 0, cycles = 0, n;
  always #2.5 clk_i = ~clk_i;
  boundary_scan_chain boundary_scan_chain_i (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tdi_i(tdi),
    .capture_dr_i(cap), .shift_dr_i(sh), .update_dr_i(upd), .external_test_instruction_i(ext),
    .snapshot_preload_instruction_i(smp), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .core_out_i(core_out), .core_oe_i(core_oe),
    .system_reset_o(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  tap_master_model tap_master_model_i (.tck_o(tck), .tdi_o(tdi), .capture_o(cap), .shift_o(sh),
    .update_o(upd), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  // --------------------------------
  // Cell map and bus helpers
  // --------------------------------
  function automatic logic is_ctl(int i);
    return i inside {29, 52, 54, 56, 58, 60, 62, 64, 66, 83, 84, 85, 87, 89, 91, 93, 95, 97, 99, 101,
                     122, 125, 130};
  endfunction
  function automatic logic is_out(int i);
    return i inside {28, 32, 33, 35, 36, 38, 39, 44, 45, 48, 49, 112, 115, 117, 119, 123, 127, 129};
  endfunction
  function automatic int ctl_of(int i);
    if (i <= 26 || i == 102 || (i >= 105 && i <= 110)) return 83;
    if (i == 103 || i == 104 || i == 114) return 84;
    if (i >= 67 && i <= 82) return 85;
    if (i == 28) return 29;
    if (i == 129) return 130;
    if ((i >= 51 && i <= 65 && i % 2 == 1) || (i >= 86 && i <= 100 && i % 2 == 0) || i == 121 || i == 124)
      return i + 1;
    return -1;
  endfunction
  function automatic logic [131:0] cap_exp(logic [131:0] p, logic [131:0] c);
    for (int i = 0; i < 132; i++) cap_exp[i] = (is_ctl(i) || is_out(i)) ? c[i] : p[i];
  endfunction
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= wd;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 40);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    `CHK(k < 40, 1'b1, "no bus answer")
  endtask
  task automatic rd_vec(input logic [7:0] a, output logic [131:0] vv);
    logic [159:0] t;
    logic [31:0]  r;
    for (int w = 0; w < 5; w++) begin
      wb(1'b1, `REG_WORD_SEL, 32'(w), r);
      wb(1'b0, a, 32'h0, r);
      t[32*w+:32] = r;
    end
    `CHK(t[159:132], 28'h0, "bits past chain end")
    vv = t[131:0];
  endtask
  task automatic chk_pins(input logic [131:0] lat);
    logic oe, ou;
    int   c;
    for (int i = 0; i < 132; i++) begin
      c = ctl_of(i);
      oe = 1'b0;
      ou = 1'b0;
      if (i inside {45, 49, 115, 117}) oe = !lat[i];
      else if (c >= 0 && !is_ctl(i)) begin
        oe = (c == 83 || c == 85) ? lat[c] : !lat[c];
        ou = lat[i];
      end else if (is_out(i)) begin
        oe = 1'b1;
        ou = lat[i];
      end
      `CHK(pin_oe[i], oe, "pin enable")
      `CHK(pin_out[i], ou, "pin data")
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("MISMATCH t=%0t run too long", $time);
      close_out();
    end
  end
  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 132; i++) v[i] = (is_ctl(i) && i != 83 && i != 85) || i inside {45, 49, 115, 117};
    rd_vec(`REG_LATCH_WORD, d);
    `CHK(d, v, "reset latches")
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h10, 32'h0, q);
    `CHK(q, 32'h0, "unmapped read")
    @(posedge clk_i);
    core_out <= V1;
    core_oe <= ~V1;
    pin_in <= P;
    smp <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK(pin_out, V1, "normal data")
    `CHK(pin_oe, ~V1, "normal enable")
    `CHK(sys_rst, 1'b0, "system reset idle")
    $display("test reset and normal done");
    tap_master_model_i.scan(V2, d, n);
    `CHK(d, cap_exp(P, V1), "snapshot")
    `CHK(n, 132, "tdo driven in shift")
    `CHK(tdo_oe, 1'b0, "tdo released")
    rd_vec(`REG_CHAIN_WORD, v);
    `CHK(v, V2, "chain after shift")
    rd_vec(`REG_LATCH_WORD, v);
    `CHK(v, V2, "preloaded latches")
    `CHK(pin_oe, ~V1, "no pin drive outside external test")
    $display("test snapshot done");
    @(posedge clk_i);
    smp <= 1'b0;
    ext <= 1'b1;
    pin_in <= ~P;
    repeat (6) @(posedge clk_i);
    `CHK(sys_rst, 1'b1, "system reset held")
    wb(1'b0, `REG_STATUS, 32'h0, q);
    `CHK(q, 32'h1, "status")
    for (int r = 0; r < 2; r++) begin
      tap_master_model_i.scan(r ? ~V3 : V3, d, n);
      `CHK(d, r ? cap_exp(~P, V1) : cap_exp(~P, V1), "external capture")
      repeat (6) @(posedge clk_i);
      chk_pins(r ? ~V3 : V3);
    end
    $display("test external done");
    @(posedge clk_i);
    ext <= 1'b0;
    repeat (6) @(posedge clk_i);
    tap_master_model_i.scan(V2, d, n);
    `CHK(n, 0, "tdo idle without instruction")
    rd_vec(`REG_CHAIN_WORD, v);
    `CHK(v, ~V3, "chain untouched")
    `CHK(pin_out, V1, "pins back to system")
    $display("test refused done");
    close_out();
  end
endmodule
